/* vtf_map.svh */
`ifndef VTF_MAP_SVH
`define VTF_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define VTF_OFF_CTRL     8'h00
`define VTF_OFF_STATECMD 8'h04
`define VTF_OFF_STATUS   8'h08
`define VTF_OFF_ID_LO    8'h0c
`define VTF_OFF_ID_HI    8'h10
`define VTF_OFF_COUNTS   8'h14
`define VTF_CTRL_RESET   1'h1

// ----------------------------------------
// Request flag positions (bit 1 is index 0)
// ----------------------------------------
`define VTF_FLG_SUBC     0
`define VTF_FLG_RATE     1
`define VTF_FLG_INV      2
`define VTF_FLG_EXT      3
`define VTF_FLG_SEL      4
`define VTF_FLG_ADDR     5

// ----------------------------------------
// State commands written to STATECMD
// ----------------------------------------
`define VTF_SCMD_QUIET   2'h1
`define VTF_SCMD_SELECT  2'h2
`define VTF_SCMD_READY   2'h3

// ----------------------------------------
// Frame and CRC constants
// ----------------------------------------
`define VTF_MIN_BYTES    5'h04
`define VTF_CRC_INIT     16'hffff
`define VTF_CRC_POLY     16'h8408
`define VTF_CRC_RESIDUE  16'hf0b8
`define VTF_RESP_ERRFLAG 8'h01
`define VTF_ERR_OPTION   8'h03

`endif

/* vtf_pkg.sv */
package vtf_pkg;
  typedef enum logic [1:0] {VTF_OFF, VTF_READY, VTF_QUIET, VTF_SELECTED} vtf_state_e;
  typedef enum logic [1:0] {VTF_SILENT, VTF_EXEC, VTF_ERROR} vtf_verdict_e;
endpackage : vtf_pkg

/* vtf_crc_if.sv */
`timescale 1ns/10ps
interface vtf_crc_if;
  logic        clear;
  logic        valid;
  logic [7:0]  data;
  logic [15:0] crc;
  logic        residueOk;
  modport user   (output clear, output valid, output data, input crc, input residueOk);
  modport engine (input clear, input valid, input data, output crc, output residueOk);
endinterface : vtf_crc_if

/* vtf_crc16.sv */
`timescale 1ns/10ps
`include "vtf_map.svh"
module vtf_crc16 (
  input wire logic core_clk,
  input wire logic reset_n,
  vtf_crc_if.engine port
);
  // Bytewise reflected CRC, least significant bit first
  function automatic logic [15:0] vtfStep(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ `VTF_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : vtfStep

  logic [15:0] crc_reg;

  always_ff @(posedge core_clk) begin
    if (!reset_n || port.clear) begin
      crc_reg <= `VTF_CRC_INIT;
    end else if (port.valid) begin
      crc_reg <= vtfStep(crc_reg, port.data);
    end
  end

  assign port.crc       = crc_reg;
  // Register holds the magic residue once the sent CRC is absorbed
  assign port.residueOk = (crc_reg == `VTF_CRC_RESIDUE);
endmodule : vtf_crc16

/* vtf_request_filter.sv */
`timescale 1ns/10ps
`include "vtf_map.svh"
// What this block does
// - Tag transmits only after a request was received and decoded.
// - Response is SOF, flags, parameters, data, CRC, EOF; no command code.
// - Frames hold whole bytes; a partial byte drops the frame.
// - Bytes LSB first; multi-byte fields least significant byte first.
// - Optional fields present only when their flag is one.
// - Four states; ready on energy, unpowered on loss of energy.
// - Ready answers requests without selection flag, ignores those with it unless also addressed (error response).
// - Quiet ignores non-addressed requests; answers matching addressed non-inventory ones.
// - Selected answers select, matching addressed and general requests.
// - Addressed requests execute only when the identifier matches.
// - Non-addressed requests carry no identifier; every eligible tag executes.
// - Selection-flag requests execute only in the selected state.
// - Flag byte is eight bits; inventory bit chooses meaning of bits 5-8.
// - Flag bit 1 picks one or two response subcarriers.
// - Flag bit 2 picks low or high response data rate.
// - Bit 5 is the selection flag when the inventory bit is zero.
// - Bit 6 is the addressing flag; identifier present when one.
// - Bad CRC with all-ones start value drops the frame silently.
// - Inventory: bit 5 family field present, bit 6 one slot or sixteen.
module vtf_request_filter
  import vtf_pkg::*;
#(
  parameter int          ID_BYTES     = 8,
  parameter logic [63:0] TAG_ID_RESET = 64'h0123_4567_89ab_cdef  // Arbitrary value
) (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fieldOk,
  input  wire logic        rxSof,
  input  wire logic        rxValid,
  input  wire logic [7:0]  rxByte,
  input  wire logic        rxEof,
  input  wire logic        rxPartial,
  output logic             execPulse,
  output logic      [7:0]  execCmd,
  output logic      [7:0]  execFlags,
  output logic             respTwoSubcarriers,
  output logic             respHighRate,
  output logic             familyFieldPresent,
  output logic             slotCountSelect,
  output logic             txValid,
  output logic      [7:0]  txByte,
  output logic             txSof,
  output logic             txEof,
  output logic      [1:0]  tagState
);
  initial begin
    if (ID_BYTES < 1 || ID_BYTES > 8) begin
      $error("ID_BYTES must be 1 to 8");
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] regIndex(input logic [7:0] a);
    case (a)
      `VTF_OFF_CTRL:     return 3'h0;
      `VTF_OFF_STATECMD: return 3'h1;
      `VTF_OFF_STATUS:   return 3'h2;
      `VTF_OFF_ID_LO:    return 3'h3;
      `VTF_OFF_ID_HI:    return 3'h4;
      `VTF_OFF_COUNTS:   return 3'h5;
      default:           return 3'h7;
    endcase
  endfunction : regIndex

  function automatic vtf_verdict_e verdict(input vtf_state_e s, input logic [7:0] f,
                                           input logic idOk);
    if (s == VTF_OFF) begin
      return VTF_SILENT;
    end else if (f[`VTF_FLG_INV]) begin
      // Inventory: non-addressed, quiet tags stay out
      return (s == VTF_QUIET) ? VTF_SILENT : VTF_EXEC;
    end else if (f[`VTF_FLG_SEL] && f[`VTF_FLG_ADDR]) begin
      return VTF_ERROR;
    end else if (f[`VTF_FLG_SEL]) begin
      return (s == VTF_SELECTED) ? VTF_EXEC : VTF_SILENT;
    end else if (f[`VTF_FLG_ADDR]) begin
      return idOk ? VTF_EXEC : VTF_SILENT;
    end else begin
      return (s == VTF_QUIET) ? VTF_SILENT : VTF_EXEC;
    end
  endfunction : verdict

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  vtf_state_e   state_reg;
  logic         enable_reg;
  logic [63:0]  tagId_reg;
  logic [15:0]  accCount_reg;
  logic [15:0]  dropCount_reg;
  logic         inFrame_reg;
  logic [4:0]   byteCnt_reg;
  logic [7:0]   flags_reg;
  logic [7:0]   cmd_reg;
  logic         idMatch_reg;
  logic         txBusy_reg;
  logic [1:0]   txIdx_reg;
  logic [7:0]   txCur;
  logic         apbWrite;
  logic         apbSetup;
  logic         frameGood;
  logic [4:0]   needBytes;
  vtf_verdict_e decision;

  vtf_crc_if rxCrc ();
  vtf_crc_if txCrc ();

  vtf_crc16 u_rxCrc (.core_clk(core_clk), .reset_n(reset_n), .port(rxCrc.engine));
  vtf_crc16 u_txCrc (.core_clk(core_clk), .reset_n(reset_n), .port(txCrc.engine));

  // ----------------------------------------
  // APB slave, zero wait states
  // ----------------------------------------
  assign apbSetup = psel && !penable;
  assign apbWrite = psel && penable && pready && pwrite;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup && (regIndex(paddr) == 3'h7);
      if (apbSetup && !pwrite) begin
        case (regIndex(paddr))
          3'h0:    prdata <= {31'h0000_0000, enable_reg};
          3'h2:    prdata <= {8'h00, cmd_reg, flags_reg, 6'h00, state_reg};
          3'h3:    prdata <= tagId_reg[31:0];
          3'h4:    prdata <= tagId_reg[63:32];
          3'h5:    prdata <= {dropCount_reg, accCount_reg};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      enable_reg <= `VTF_CTRL_RESET;
      tagId_reg  <= TAG_ID_RESET;
    end else if (apbWrite) begin
      case (regIndex(paddr))
        3'h0:    enable_reg <= pwdata[0];
        3'h3:    tagId_reg[31:0] <= pwdata;
        3'h4:    tagId_reg[63:32] <= pwdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Tag state machine
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n || !fieldOk) begin
      state_reg <= VTF_OFF;
    end else begin
      case (state_reg)
        VTF_OFF: state_reg <= VTF_READY;
        VTF_READY, VTF_QUIET, VTF_SELECTED: begin
          // Command executor requests moves through STATECMD
          if (apbWrite && regIndex(paddr) == 3'h1) begin
            case (pwdata[1:0])
              `VTF_SCMD_QUIET:  state_reg <= VTF_QUIET;
              `VTF_SCMD_SELECT: state_reg <= VTF_SELECTED;
              `VTF_SCMD_READY:  state_reg <= VTF_READY;
              default:          ;
            endcase
          end
        end
        default: state_reg <= VTF_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      tagState <= 2'h0;
    end else begin
      tagState <= state_reg;
    end
  end

  // ----------------------------------------
  // Request reception
  // ----------------------------------------
  assign rxCrc.clear = rxSof;
  assign rxCrc.valid = rxValid && inFrame_reg;
  assign rxCrc.data  = rxByte;

  // Identifier bytes follow the command only in addressed mode
  assign needBytes = (!flags_reg[`VTF_FLG_INV] && flags_reg[`VTF_FLG_ADDR])
                   ? `VTF_MIN_BYTES + 5'(ID_BYTES) : `VTF_MIN_BYTES;
  assign frameGood = !rxPartial
                  && rxCrc.residueOk
                  && byteCnt_reg >= needBytes
                  && !flags_reg[`VTF_FLG_EXT];
  assign decision  = verdict(state_reg, flags_reg, idMatch_reg);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      inFrame_reg <= 1'b0;
      byteCnt_reg <= 5'h00;
      flags_reg   <= 8'h00;
      cmd_reg     <= 8'h00;
      idMatch_reg <= 1'b0;
    end else if (rxSof) begin
      inFrame_reg <= 1'b1;
      byteCnt_reg <= 5'h00;
      idMatch_reg <= 1'b1;
    end else if (rxEof) begin
      inFrame_reg <= 1'b0;
    end else if (rxValid && inFrame_reg) begin
      if (byteCnt_reg != 5'h1f) begin
        byteCnt_reg <= byteCnt_reg + 5'h01;
      end
      if (byteCnt_reg == 5'h00) begin
        flags_reg <= rxByte;
      end
      if (byteCnt_reg == 5'h01) begin
        cmd_reg <= rxByte;
      end
      // Identifier arrives least significant byte first
      if (!flags_reg[`VTF_FLG_INV] && flags_reg[`VTF_FLG_ADDR]
          && byteCnt_reg >= 5'h02 && byteCnt_reg < 5'(ID_BYTES + 2)
          && rxByte != tagId_reg[8 * (byteCnt_reg - 5'h02) +: 8]) begin
        idMatch_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Verdict and executor hand-off
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      execPulse          <= 1'b0;
      execCmd            <= 8'h00;
      execFlags          <= 8'h00;
      respTwoSubcarriers <= 1'b0;
      respHighRate       <= 1'b0;
      familyFieldPresent <= 1'b0;
      slotCountSelect    <= 1'b0;
      accCount_reg       <= 16'h0000;
      dropCount_reg      <= 16'h0000;
    end else begin
      execPulse <= 1'b0;
      if (rxEof && inFrame_reg && enable_reg) begin
        if (!frameGood) begin
          dropCount_reg <= dropCount_reg + 16'h0001;
        end else if (decision != VTF_SILENT) begin
          execPulse          <= (decision == VTF_EXEC);
          execCmd            <= cmd_reg;
          execFlags          <= flags_reg;
          respTwoSubcarriers <= flags_reg[`VTF_FLG_SUBC];
          respHighRate       <= flags_reg[`VTF_FLG_RATE];
          familyFieldPresent <= flags_reg[`VTF_FLG_INV] && flags_reg[`VTF_FLG_SEL];
          slotCountSelect    <= flags_reg[`VTF_FLG_INV] && flags_reg[`VTF_FLG_ADDR];
          accCount_reg       <= accCount_reg + 16'h0001;
        end
      end
    end
  end

  // ----------------------------------------
  // Error response framer
  // ----------------------------------------
  // Bytes: flags, error code, then CRC complement low byte first
  always_comb begin
    case (txIdx_reg)
      2'h0:    txCur = `VTF_RESP_ERRFLAG;
      2'h1:    txCur = `VTF_ERR_OPTION;
      2'h2:    txCur = ~txCrc.crc[7:0];
      default: txCur = ~txCrc.crc[15:8];
    endcase
  end

  assign txCrc.clear = !txBusy_reg;
  assign txCrc.valid = txBusy_reg && !txIdx_reg[1];
  assign txCrc.data  = txCur;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      txBusy_reg <= 1'b0;
      txIdx_reg  <= 2'h0;
      txValid    <= 1'b0;
      txByte     <= 8'h00;
      txSof      <= 1'b0;
      txEof      <= 1'b0;
    end else begin
      txValid <= txBusy_reg;
      txByte  <= txBusy_reg ? txCur : 8'h00;
      txSof   <= txBusy_reg && txIdx_reg == 2'h0;
      txEof   <= txBusy_reg && txIdx_reg == 2'h3;
      if (txBusy_reg) begin
        txIdx_reg  <= txIdx_reg + 2'h1;
        txBusy_reg <= (txIdx_reg != 2'h3);
      end else if (rxEof && inFrame_reg && enable_reg && frameGood
                   && decision == VTF_ERROR) begin
        // Only a decoded request can start a transmission
        txBusy_reg <= 1'b1;
        txIdx_reg  <= 2'h0;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_errBody;
    txByte == `VTF_RESP_ERRFLAG ##1 txByte == `VTF_ERR_OPTION ##2 txEof;
  endsequence

  property p_noSpontaneous;
    $rose(txSof) |-> $past(rxEof, 2);
  endproperty
  a_noSpontaneous: assert property (p_noSpontaneous) else $error("tx without request");

  property p_errFrame;
    txSof |-> s_errBody;
  endproperty
  a_errFrame: assert property (p_errFrame) else $error("bad error response");

  property p_fieldLoss;
    !fieldOk |=> state_reg == VTF_OFF ##1 tagState == 2'h0;
  endproperty
  a_fieldLoss: assert property (p_fieldLoss) else $error("state kept without field");

  property p_partialDrop;
    rxEof && rxPartial |=> !execPulse && !txBusy_reg;
  endproperty
  a_partialDrop: assert property (p_partialDrop) else $error("partial frame accepted");

  property p_crcDrop;
    rxEof && inFrame_reg && !rxCrc.residueOk |=> !execPulse && !txBusy_reg;
  endproperty
  a_crcDrop: assert property (p_crcDrop) else $error("bad CRC accepted");

  property p_selectOnly;
    execPulse && !execFlags[`VTF_FLG_INV] && execFlags[`VTF_FLG_SEL]
      |-> $past(state_reg) == VTF_SELECTED;
  endproperty
  a_selectOnly: assert property (p_selectOnly) else $error("select request off state");

  property p_addrMatch;
    execPulse && !execFlags[`VTF_FLG_INV] && execFlags[`VTF_FLG_ADDR] |-> $past(idMatch_reg);
  endproperty
  a_addrMatch: assert property (p_addrMatch) else $error("addressed without match");

  property p_quietGeneral;
    execPulse && !execFlags[`VTF_FLG_ADDR] |-> $past(state_reg) != VTF_QUIET;
  endproperty
  a_quietGeneral: assert property (p_quietGeneral) else $error("quiet tag answered");

  property p_readyGeneral;
    rxEof && inFrame_reg && enable_reg && frameGood && state_reg == VTF_READY
      && !flags_reg[`VTF_FLG_INV] && !flags_reg[`VTF_FLG_SEL] && !flags_reg[`VTF_FLG_ADDR]
      |=> execPulse && respHighRate == execFlags[`VTF_FLG_RATE];
  endproperty
  a_readyGeneral: assert property (p_readyGeneral) else $error("general request missed");
endmodule : vtf_request_filter

/* vtf_reader_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Reader side of the request link
// ----------------------------------------
module vtf_reader_model (
  input  wire logic       core_clk,
  output logic            rxSof,
  output logic            rxValid,
  output logic      [7:0] rxByte,
  output logic            rxEof,
  output logic            rxPartial
);
  initial begin
    rxSof     = 1'b0;
    rxValid   = 1'b0;
    rxByte    = 8'h00;
    rxEof     = 1'b0;
    rxPartial = 1'b0;
  end

  // Transmitted form: register complemented
  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] r;
    r = 16'hffff;
    foreach (q[i]) begin
      r = r ^ {8'h00, q[i]};
      for (int b = 0; b < 8; b++) begin
        r = r[0] ? ((r >> 1) ^ 16'h8408) : (r >> 1);
      end
    end
    return ~r;
  endfunction : crc_of

  // Gap of zero sends bytes back to back; larger gaps model a slow reader
  task automatic send_frame(input logic [7:0] q[$], input bit bad, input bit part,
                            input int gap);
    logic [15:0] c;
    c = crc_of(q);
    q.push_back(c[7:0] ^ {7'h00, bad});
    q.push_back(c[15:8]);
    @(posedge core_clk);
    rxSof <= 1'b1;
    @(posedge core_clk);
    rxSof <= 1'b0;
    foreach (q[i]) begin
      rxValid <= 1'b1;
      rxByte  <= q[i];
      @(posedge core_clk);
      if (gap > 0 || i == q.size() - 1) begin
        rxValid <= 1'b0;
        rxByte  <= ~q[i];
        repeat (gap) @(posedge core_clk);
      end
    end
    if (gap == 0) @(posedge core_clk);
    rxEof     <= 1'b1;
    rxPartial <= part;
    @(posedge core_clk);
    rxEof     <= 1'b0;
    rxPartial <= 1'b0;
  endtask : send_frame
endmodule : vtf_reader_model

/* vtf_request_filter_tb.sv */
`timescale 1ns/10ps
`include "vtf_map.svh"
module vtf_request_filter_tb
  import vtf_pkg::*;
;
  typedef logic [7:0] vtf_bytes_t[$];
  localparam logic [63:0] TAG_ID = 64'h1122_3344_5566_7788; // Arbitrary value

  logic        core_clk;
  logic        reset_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        fieldOk;
  logic        rxSof;
  logic        rxValid;
  logic [7:0]  rxByte;
  logic        rxEof;
  logic        rxPartial;
  logic        execPulse;
  logic [7:0]  execCmd;
  logic [7:0]  execFlags;
  logic        respTwoSubcarriers;
  logic        respHighRate;
  logic        familyFieldPresent;
  logic        slotCountSelect;
  logic        txValid;
  logic [7:0]  txByte;
  logic        txSof;
  logic        txEof;
  logic [1:0]  tagState;
  int          badCount;
  int          comparisons;
  int          cycles;
  int          execSeen;
  int          sofSeen;
  int          eofSeen;
  int          gapSel;
  vtf_bytes_t  txSeen;
  logic [31:0] rd;
  logic        err;
  logic [15:0] c;

  vtf_request_filter #(.ID_BYTES(8), .TAG_ID_RESET(TAG_ID)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fieldOk(fieldOk), .rxSof(rxSof),
    .rxValid(rxValid), .rxByte(rxByte), .rxEof(rxEof), .rxPartial(rxPartial),
    .execPulse(execPulse), .execCmd(execCmd), .execFlags(execFlags),
    .respTwoSubcarriers(respTwoSubcarriers), .respHighRate(respHighRate),
    .familyFieldPresent(familyFieldPresent), .slotCountSelect(slotCountSelect),
    .txValid(txValid), .txByte(txByte), .txSof(txSof), .txEof(txEof),
    .tagState(tagState)
  );

  vtf_reader_model rdr_u (
    .core_clk(core_clk), .rxSof(rxSof), .rxValid(rxValid), .rxByte(rxByte),
    .rxEof(rxEof), .rxPartial(rxPartial)
  );

  // ----------------------------------------
  // Clock, watchdog and bookkeeping
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      badCount++;
      close_out();
    end
  end

  task automatic close_out();
    if (badCount == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  // Zero-wait slave, but the wait is open-ended up to the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // Answer is taken at the same rising edge that shows pready high
    do @(posedge core_clk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic watch();
    execSeen = 0;
    sofSeen  = 0;
    eofSeen  = 0;
    txSeen   = {};
    repeat (12) begin
      @(negedge core_clk);
      if (execPulse === 1'b1) execSeen++;
      if (txSof === 1'b1) sofSeen++;
      if (txEof === 1'b1) eofSeen++;
      if (txValid === 1'b1) txSeen.push_back(txByte);
    end
  endtask : watch

  task automatic req(input vtf_bytes_t q, input bit bad, input bit part, input int exp);
    gapSel = 2 - gapSel;
    rdr_u.send_frame(q, bad, part, gapSel);
    watch();
    check(execSeen, exp, "request accepted count");
  endtask : req

  function automatic vtf_bytes_t addr_frame(input logic [7:0] f, input logic [63:0] id);
    vtf_bytes_t q;
    q = {f, 8'h23};
    for (int i = 0; i < 8; i++) q.push_back(id[8*i +: 8]);
    return q;
  endfunction : addr_frame

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    fieldOk = 1'b1;
    badCount = 0;
    comparisons = 0;
    cycles = 0;
    gapSel = 0;
    repeat (10) @(posedge core_clk);
    check({30'h0, tagState}, 32'(VTF_OFF), "state in reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({30'h0, tagState}, 32'(VTF_READY), "state after power");
    apb(1'b0, `VTF_OFF_CTRL, 32'h0);
    check(rd, 32'h1, "enable reset value");
    apb(1'b0, `VTF_OFF_ID_LO, 32'h0);
    check(rd, TAG_ID[31:0], "identifier low");
    apb(1'b0, `VTF_OFF_ID_HI, 32'h0);
    check(rd, TAG_ID[63:32], "identifier high");
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    watch();
    check(txSeen.size() + sofSeen, 0, "unsolicited transmit");
    req({8'h02, 8'h20}, 1'b0, 1'b0, 1);
    check({execCmd, execFlags}, 32'h2002, "command and flags");
    check({respTwoSubcarriers, respHighRate}, 32'h1, "rate and subcarrier");
    req({8'h12, 8'h20}, 1'b0, 1'b0, 0);
    req({8'h02, 8'h20}, 1'b1, 1'b0, 0);
    req({8'h02, 8'h20}, 1'b0, 1'b1, 0);
    req({8'h0a, 8'h20}, 1'b0, 1'b0, 0);
    req(addr_frame(8'h21, TAG_ID), 1'b0, 1'b0, 1);
    check({respTwoSubcarriers, respHighRate}, 32'h2, "two subcarriers");
    req(addr_frame(8'h21, TAG_ID ^ 64'h0100), 1'b0, 1'b0, 0);
    req({8'h36, 8'h01, 8'h00, 8'h00}, 1'b0, 1'b0, 1);
    check({familyFieldPresent, slotCountSelect}, 32'h3, "inventory fields");
    req({8'h06, 8'h01, 8'h00}, 1'b0, 1'b0, 1);
    check({familyFieldPresent, slotCountSelect}, 32'h0, "inventory fields");
    apb(1'b1, `VTF_OFF_STATECMD, {30'h0, `VTF_SCMD_QUIET});
    apb(1'b0, `VTF_OFF_STATUS, 32'h0);
    check({30'h0, rd[1:0]}, 32'(VTF_QUIET), "quiet state");
    req({8'h02, 8'h20}, 1'b0, 1'b0, 0);
    req({8'h26, 8'h01, 8'h00}, 1'b0, 1'b0, 0);
    req(addr_frame(8'h20, TAG_ID), 1'b0, 1'b0, 1);
    apb(1'b1, `VTF_OFF_STATECMD, {30'h0, `VTF_SCMD_SELECT});
    req({8'h12, 8'h20}, 1'b0, 1'b0, 1);
    req({8'h02, 8'h20}, 1'b0, 1'b0, 1);
    req(addr_frame(8'h20, TAG_ID), 1'b0, 1'b0, 1);
    req(addr_frame(8'h32, TAG_ID), 1'b0, 1'b0, 0);
    c = rdr_u.crc_of({`VTF_RESP_ERRFLAG, `VTF_ERR_OPTION});
    check(txSeen.size(), 4, "error length");
    if (txSeen.size() == 4) begin
      check({txSeen[0], txSeen[1]}, 32'h0103, "error flag and code");
      check({txSeen[3], txSeen[2]}, {16'h0, c}, "error crc");
    end
    check({sofSeen[7:0], eofSeen[7:0]}, 32'h0101, "error framing");
    @(posedge core_clk);
    fieldOk <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({30'h0, tagState}, 32'(VTF_OFF), "state on field loss");
    req({8'h02, 8'h20}, 1'b0, 1'b0, 0);
    @(posedge core_clk);
    fieldOk <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    check({30'h0, tagState}, 32'(VTF_READY), "state on field return");
    close_out();
  end
endmodule : vtf_request_filter_tb
